/* design/cpd_params.svh */
// Constants for the codec port DMA channel configuration block.
// Assumes inclusion by bare name from files that need register offsets or fields.
`ifndef CPD_PARAMS_SVH
`define CPD_PARAMS_SVH

// ************************************************************
// register indices (byte address = index * 4)
// ************************************************************
`define CPD_IDX_CTL        16'hFFE8
`define CPD_IDX_SLOT_HI    16'hFFE9
`define CPD_IDX_SLOT_LO    16'hFFEA
`define CPD_IDX_STATUS     16'hFFEB

// ************************************************************
// bus geometry
// ************************************************************
`define CPD_ADDR_W         18
`define CPD_IDX_LSB        2
`define CPD_DATA_W         32
`define CPD_REG_W          8
`define CPD_READ_ZERO      32'h0000_0000
`define CPD_REG_RST        8'h00

// ************************************************************
// control register fields
// ************************************************************
`define CPD_CTL_EN         7
`define CPD_CTL_DIR        3
`define CPD_CTL_EP_HI      2
`define CPD_CTL_EP_LO      0
`define CPD_CTL_WMASK      8'h8F

// ************************************************************
// slot registers and status fields
// ************************************************************
`define CPD_NUM_SLOTS      14
`define CPD_SLOT_LO_BITS   8
`define CPD_HI_BYTES_PER_SLOT_HI     7
`define CPD_HI_BYTES_PER_SLOT_LO     6
`define CPD_HI_SLOT_HI     5
`define CPD_STAT_BUSY      0
`define CPD_STAT_OVR       1
`define CPD_STAT_SLOT_LO   4
`define CPD_EP_NONE        3'h0

`endif

/* design/cpd_pkg.sv */
// Types shared by the codec port DMA channel configuration block.
// Assumes cpd_params.svh is available on the include path.
`include "cpd_params.svh"

package cpd_pkg;

  // channel settings as software programmed them
  typedef struct packed {
    logic                       enable;
    logic                       dir_in;
    logic [2:0]                 endpoint_select;
    logic [`CPD_NUM_SLOTS-1:0]  slot_select_bits;
    logic [1:0]                 bytes_per_slot;
  } cpd_cfg_t;

  // one byte move handed to the transfer engine
  typedef struct packed {
    logic       dir_in;
    logic [2:0] endpoint_select;
    logic [3:0] slot;
    logic       last;
  } cpd_beat_t;

  typedef enum logic [0:0] {
    CPD_IDLE,
    CPD_MOVE
  } cpd_state_t;

endpackage

/* design/cpd_slot_engine.sv */
// Slot engine: turns codec port slot strobes into byte move descriptors.
// Assumes slot_strobe is a one-cycle pulse synchronous to clk.
`timescale 1ns/1ps
`include "cpd_params.svh"

module cpd_slot_engine (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // configuration
  input  wire cpd_pkg::cpd_cfg_t cfg,
  // codec port slot timing
  input  wire logic              slot_strobe,
  input  wire logic [3:0]        slot_num,
  // byte move descriptors
  output logic                   beat_valid,
  output cpd_pkg::cpd_beat_t     beat,
  input  wire logic              beat_ready,
  // status
  output logic                   busy,
  output logic                   overrun
);

  cpd_pkg::cpd_state_t        state;
  logic [1:0]                 beats_left;
  logic [`CPD_NUM_SLOTS-1:0]  slot_hit;
  logic                       active;
  logic                       hit;

  // ************************************************************
  // slot decode
  // ************************************************************
  genvar i;
  generate
    for (i = 0; i < `CPD_NUM_SLOTS; i++) begin : g_slot
      assign slot_hit[i] = cfg.slot_select_bits[i] && (slot_num == 4'(i));
    end
  endgenerate

  // endpoint 0 belongs to control transfers and is never served
  assign active = cfg.enable && (cfg.endpoint_select != `CPD_EP_NONE);
  assign hit    = slot_strobe && active && (|slot_hit);

  assign beat_valid = (state == cpd_pkg::CPD_MOVE);
  assign busy       = beat_valid;
  // a selected slot that arrives while the previous one is still moving is lost
  assign overrun    = hit && beat_valid;

  // ************************************************************
  // sequencer
  // ************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state      <= cpd_pkg::CPD_IDLE;
      beats_left <= 2'h0;
    end else begin
      unique case (state)
        cpd_pkg::CPD_IDLE: begin
          if (hit) begin
            state      <= cpd_pkg::CPD_MOVE;
            beats_left <= cfg.bytes_per_slot;
          end
        end
        cpd_pkg::CPD_MOVE: begin
          if (!cfg.enable) begin
            state <= cpd_pkg::CPD_IDLE;
          end else if (beat_ready) begin
            if (beats_left == 2'h0) begin
              state <= cpd_pkg::CPD_IDLE;
            end else begin
              beats_left <= beats_left - 2'h1;
            end
          end
        end
      endcase
    end
  end

  // ************************************************************
  // descriptor register
  // ************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      beat <= '0;
    end else if (state == cpd_pkg::CPD_IDLE && hit) begin
      beat.dir_in          <= cfg.dir_in;
      beat.endpoint_select <= cfg.endpoint_select;
      beat.slot            <= slot_num;
      beat.last            <= (cfg.bytes_per_slot == 2'h0);
    end else if (beat_valid && beat_ready) begin
      beat.last <= (beats_left == 2'h1);
    end
  end

endmodule

/* design/cpd_dma_config.sv */
// Codec port DMA channel configuration: Avalon-MM register slave plus slot engine.
// Assumes the bus master holds each request until waitrequest is low.
//
// How it works
// - direction bit 1 means in endpoint
// - slot bit 1 means slot served
// - each selected slot moves data, direction-bit steered (here endpoint 0 serves no slot, and one arriving while busy is lost)
// - exactly fourteen slot selection bits
// - low slot register holds slots 7:0
// - high register: slots 13:8, bytes-per-slot 7:6
// - bytes-per-slot code plus one bytes
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ps
`include "cpd_params.svh"

module cpd_dma_config (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  // avalon-mm slave
  input  wire logic [`CPD_ADDR_W-1:0]  avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [`CPD_DATA_W-1:0]  avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic [`CPD_DATA_W-1:0]       avs_readdata,
  output logic                         avs_waitrequest,
  // codec port slot timing
  input  wire logic                    slot_strobe,
  input  wire logic [3:0]              slot_num,
  // byte move descriptors to the transfer engine
  output logic                         beat_valid,
  output cpd_pkg::cpd_beat_t           beat,
  input  wire logic                    beat_ready
);

  logic                               ack;
  logic                               req;
  logic                               wr_go;
  logic [15:0]                        idx;
  logic [`CPD_DATA_W-1:0]             next_readdata;
  logic                               sel_ctl;
  logic                               sel_hi;
  logic                               sel_lo;
  logic                               sel_stat;

  logic                               channel_enable_bit;
  logic                               endpoint_direction_bit;
  logic [2:0]                         endpoint_select;
  logic [`CPD_NUM_SLOTS-1:0]          slot_select_bits;
  logic [`CPD_SLOT_LO_BITS-1:0]       slot_lo;
  logic [`CPD_NUM_SLOTS-`CPD_SLOT_LO_BITS-1:0] slot_hi;
  logic [1:0]                         bytes_per_slot;
  logic                               overrun_flag;
  logic [3:0]                         last_slot;

  cpd_pkg::cpd_cfg_t                  cfg;
  logic                               busy;
  logic                               overrun;

  // ************************************************************
  // bus handshake
  // ************************************************************
  // one wait cycle on every access keeps the read mux off the critical path
  assign req             = avs_read || avs_write;
  assign avs_waitrequest = req && !ack;
  assign wr_go           = avs_write && ack && avs_byteenable[0];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack <= 1'b0;
    end else begin
      ack <= req && !ack;
    end
  end

  // ************************************************************
  // address decode
  // ************************************************************
  assign idx      = avs_address[`CPD_ADDR_W-1:`CPD_IDX_LSB];
  assign sel_ctl  = (idx == `CPD_IDX_CTL);
  assign sel_hi   = (idx == `CPD_IDX_SLOT_HI);
  assign sel_lo   = (idx == `CPD_IDX_SLOT_LO);
  assign sel_stat = (idx == `CPD_IDX_STATUS);

  // ************************************************************
  // control register
  // ************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      channel_enable_bit     <= 1'b0;
      endpoint_direction_bit <= 1'b0;
      endpoint_select        <= 3'h0;
    end else if (wr_go && sel_ctl) begin
      // bits 6:4 are not stored; writes to them are dropped
      channel_enable_bit     <= avs_writedata[`CPD_CTL_EN];
      endpoint_direction_bit <= avs_writedata[`CPD_CTL_DIR];
      endpoint_select        <= avs_writedata[`CPD_CTL_EP_HI:`CPD_CTL_EP_LO];
    end
  end

  // ************************************************************
  // slot assignment registers
  // ************************************************************
  // no interlock against enable: the engine sees new slot bits at once
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      slot_lo <= `CPD_REG_RST;
    end else if (wr_go && sel_lo) begin
      slot_lo <= avs_writedata[`CPD_SLOT_LO_BITS-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      slot_hi        <= 6'h00;
      bytes_per_slot <= 2'h0;
    end else if (wr_go && sel_hi) begin
      slot_hi        <= avs_writedata[`CPD_HI_SLOT_HI:0];
      bytes_per_slot <= avs_writedata[`CPD_HI_BYTES_PER_SLOT_HI:`CPD_HI_BYTES_PER_SLOT_LO];
    end
  end

  // one driver per register byte; the fourteen bits are only joined here
  assign slot_select_bits = {slot_hi, slot_lo};

  // ************************************************************
  // status register
  // ************************************************************
  // overrun is write-one-to-clear; a new overrun in the clearing cycle wins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      overrun_flag <= 1'b0;
    end else begin
      overrun_flag <= overrun || (overrun_flag && !(wr_go && sel_stat && avs_writedata[`CPD_STAT_OVR]));
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      last_slot <= 4'h0;
    end else if (beat_valid && beat_ready && beat.last) begin
      last_slot <= beat.slot;
    end
  end

  // ************************************************************
  // read path
  // ************************************************************
  always_comb begin
    next_readdata = `CPD_READ_ZERO;
    if (sel_ctl) begin
      next_readdata[`CPD_CTL_EN]                   = channel_enable_bit;
      next_readdata[`CPD_CTL_DIR]                  = endpoint_direction_bit;
      next_readdata[`CPD_CTL_EP_HI:`CPD_CTL_EP_LO] = endpoint_select;
    end else if (sel_hi) begin
      next_readdata[`CPD_HI_BYTES_PER_SLOT_HI:`CPD_HI_BYTES_PER_SLOT_LO] = bytes_per_slot;
      next_readdata[`CPD_HI_SLOT_HI:0]               = slot_select_bits[`CPD_NUM_SLOTS-1:`CPD_SLOT_LO_BITS];
    end else if (sel_lo) begin
      next_readdata[`CPD_SLOT_LO_BITS-1:0] = slot_select_bits[`CPD_SLOT_LO_BITS-1:0];
    end else if (sel_stat) begin
      next_readdata[`CPD_STAT_BUSY]           = busy;
      next_readdata[`CPD_STAT_OVR]            = overrun_flag;
      next_readdata[`CPD_STAT_SLOT_LO+3:`CPD_STAT_SLOT_LO] = last_slot;
    end
  end

  // sampled in the wait cycle so the data stands on the accepting edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= `CPD_READ_ZERO;
    end else if (avs_read && !ack) begin
      avs_readdata <= next_readdata;
    end
  end

  // ************************************************************
  // slot engine
  // ************************************************************
  assign cfg = '{enable:           channel_enable_bit,
                 dir_in:           endpoint_direction_bit,
                 endpoint_select:  endpoint_select,
                 slot_select_bits: slot_select_bits,
                 bytes_per_slot:   bytes_per_slot};

  cpd_slot_engine u_engine (
    .clk         (clk),
    .rst_b       (rst_b),
    .cfg         (cfg),
    .slot_strobe (slot_strobe),
    .slot_num    (slot_num),
    .beat_valid  (beat_valid),
    .beat        (beat),
    .beat_ready  (beat_ready),
    .busy        (busy),
    .overrun     (overrun)
  );

endmodule

/* sim/cpd_dma_config_monitor.sv */
// Checker for the codec port DMA configuration block.
// Assumes bind to cpd_dma_config; shadows the registers from bus writes.
`timescale 1ns/1ps
`include "cpd_params.svh"
module cpd_dma_config_monitor (
  // clock and reset
  input wire logic                   clk,
  input wire logic                   rst_b,
  // register bus
  input wire logic [`CPD_ADDR_W-1:0] avs_address,
  input wire logic                   avs_read,
  input wire logic                   avs_write,
  input wire logic [`CPD_DATA_W-1:0] avs_writedata,
  input wire logic [3:0]             avs_byteenable,
  input wire logic [`CPD_DATA_W-1:0] avs_readdata,
  input wire logic                   avs_waitrequest,
  // slot link
  input wire logic                   slot_strobe,
  input wire logic [3:0]             slot_num,
  input wire logic                   beat_valid,
  input wire cpd_pkg::cpd_beat_t     beat,
  input wire logic                   beat_ready
);
  logic [7:0]  ctl, hi, lo;
  logic [1:0]  cnt;
  logic [15:0] idx, sel;
  logic [31:0] exp_rd;
  logic        wr_go, take, go;
  assign idx   = avs_address[17:2];
  assign wr_go = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign take  = beat_valid && beat_ready;
  assign sel   = {2'h0, hi[5:0], lo};
  assign go    = ctl[7] && ctl[2:0] != 3'h0 && sel[slot_num];
  always_comb begin
    exp_rd = 32'h0;
    if (idx == `CPD_IDX_CTL) exp_rd[7:0] = ctl;
    if (idx == `CPD_IDX_SLOT_HI) exp_rd[7:0] = hi;
    if (idx == `CPD_IDX_SLOT_LO) exp_rd[7:0] = lo;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl <= 8'h00;
      hi  <= 8'h00;
      lo  <= 8'h00;
    end else if (wr_go) begin
      if (idx == `CPD_IDX_CTL) ctl <= avs_writedata[7:0] & `CPD_CTL_WMASK;
      if (idx == `CPD_IDX_SLOT_HI) hi <= avs_writedata[7:0];
      if (idx == `CPD_IDX_SLOT_LO) lo <= avs_writedata[7:0];
    end
  end
  // beats taken so far in the current slot; an abort clears it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) cnt <= 2'h0;
    else if (!beat_valid || (take && beat.last)) cnt <= 2'h0;
    else if (take) cnt <= cnt + 2'h1;
  end
  // *****
  // properties
  // *****
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wait_once_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request waited more than one cycle");
  wait_first_a: assert property ((avs_read || avs_write) && !$past(avs_read || avs_write) |-> avs_waitrequest)
    else $error("request answered in its first cycle");
  rd_value_a: assert property (
    avs_read && !avs_waitrequest && idx != `CPD_IDX_STATUS |-> avs_readdata == exp_rd)
    else $error("read data differs from written value");
  dir_ep_a: assert property (
    $rose(beat_valid) |-> beat.dir_in == ctl[3] && beat.endpoint_select == ctl[2:0])
    else $error("beat direction or endpoint wrong");
  slot_sel_a: assert property ($rose(beat_valid) |-> sel[beat.slot])
    else $error("beat for an unselected slot");
  slot_start_a: assert property (slot_strobe && !beat_valid && go && !wr_go |=> beat_valid)
    else $error("selected slot not served");
  slot_skip_a: assert property (slot_strobe && !beat_valid && !go |=> !beat_valid)
    else $error("slot served though not allowed");
  bytes_last_a: assert property (take && beat.last |-> cnt == hi[7:6])
    else $error("wrong beat count per slot");
  bytes_more_a: assert property (take && !beat.last |-> cnt < hi[7:6])
    else $error("last flag missing");
  beat_hold_a: assert property (beat_valid && !beat_ready && !wr_go |=> beat_valid && $stable(beat))
    else $error("beat changed while stalled");
  off_stop_a: assert property (!ctl[7] |=> !beat_valid)
    else $error("transfer while disabled");
endmodule

bind cpd_dma_config cpd_dma_config_monitor u_mon (.clk, .rst_b, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .slot_strobe, .slot_num,
  .beat_valid, .beat, .beat_ready);

/* sim/cpd_beat_sink.sv */
// Transfer engine stand-in: takes byte move descriptors, stalls at random when slow.
// Assumes one clock shared with the block.
`timescale 1ns/1ps
module cpd_beat_sink (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // stall control
  input wire logic slow,
  // handshake
  output logic     beat_ready
);
  integer seed = 32'h3FB28A32;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) beat_ready <= 1'b0;
    else beat_ready <= !slow || ($random(seed) & 3) == 0;
  end
endmodule

/* sim/codec_port_dma_channel_config_bench.sv */
// Self-checking bench for the codec port DMA configuration block.
// Assumes the design package and cpd_params.svh are compiled first.
`timescale 1ns/1ps
`include "cpd_params.svh"
module codec_port_dma_channel_config_bench;
  logic                   clk = 1'b0;
  logic                   rst_b = 1'b0;
  logic [`CPD_ADDR_W-1:0] avs_address = '0;
  logic                   avs_read = 1'b0;
  logic                   avs_write = 1'b0;
  logic [`CPD_DATA_W-1:0] avs_writedata = '0;
  logic [3:0]             avs_byteenable = 4'hF;
  logic [`CPD_DATA_W-1:0] avs_readdata;
  logic                   avs_waitrequest, beat_valid, beat_ready;
  logic                   slot_strobe = 1'b0;
  logic                   slow = 1'b0;
  logic [3:0]             slot_num = 4'h0;
  cpd_pkg::cpd_beat_t     beat;
  cpd_pkg::cpd_beat_t     beat_q[$];
  logic [7:0]             rd_q[$];
  integer                 seed = 32'h3FB28A32;
  int                     miscompares = 0;
  int                     n_tests = 0;
  int                     i, s, b;
  logic [7:0]             lo, hi, ctl;
  logic [15:0]            sel;
  logic [3:0]             last = 4'h0;
  always #25 clk = ~clk;
  cpd_dma_config dut (.clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .slot_strobe, .slot_num, .beat_valid,
    .beat, .beat_ready);
  cpd_beat_sink sink (.clk, .rst_b, .slow, .beat_ready);
  // *****
  // tasks
  // *****
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task cmp_rd(input logic [31:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== {24'h0, exp}) begin
      miscompares++;
      $display("[FAIL] %0t read %h expected %h", $time, got, exp);
    end
  endtask
  task cmp_beat(input cpd_pkg::cpd_beat_t got, input cpd_pkg::cpd_beat_t exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t beat %h expected %h", $time, got, exp);
    end
  endtask
  // upper data bits and address bits 1:0 are random: the block must ignore them
  task bus(input logic w, input logic [15:0] idx, input logic [7:0] d, input logic [3:0] be);
    logic [31:0] r;
    r = $random(seed);
    @(posedge clk);
    avs_address <= {idx, r[1:0]};
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {r[31:8], d};
    avs_byteenable <= be;
    // released only after the edge that samples waitrequest low; a hang ends at the watchdog
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task rd(input logic [15:0] idx, input logic [7:0] exp);
    rd_q.push_back(exp);
    bus(1'b0, idx, 8'h00, 4'hF);
  endtask
  // len above one repeats the strobe while the slot is still moving
  task strobe(input logic [3:0] n, input int len = 1);
    @(posedge clk);
    slot_strobe <= 1'b1;
    slot_num <= n;
    repeat (len) @(posedge clk);
    slot_strobe <= 1'b0;
    while (beat_q.size() != 0 || beat_valid !== 1'b0) begin
      @(posedge clk);
    end
    repeat (3) @(posedge clk);
  endtask
  // *****
  // result watcher
  // *****
  // handshakes are judged at the rising edge that completes them
  always @(posedge clk) begin
    if (avs_read && !avs_waitrequest)
      cmp_rd(avs_readdata, rd_q.size() != 0 ? rd_q.pop_front() : 8'hXX);
    if (beat_valid && beat_ready)
      cmp_beat(beat, beat_q.size() != 0 ? beat_q.pop_front() : 'x);
  end
  initial begin
    #(30000 * 50);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    rd(`CPD_IDX_CTL, 8'h00);
    rd(`CPD_IDX_SLOT_HI, 8'h00);
    rd(`CPD_IDX_SLOT_LO, 8'h00);
    rd(16'h0010, 8'h00);
    bus(1'b1, `CPD_IDX_CTL, 8'h70, 4'hF);
    rd(`CPD_IDX_CTL, 8'h00);
    bus(1'b1, `CPD_IDX_SLOT_LO, 8'hAA, 4'hE);
    rd(`CPD_IDX_SLOT_LO, 8'h00);
    // every size code in direction in, codes 1-3 out; endpoint 0 on the first pass, so code 0 out moves nothing
    for (i = 0; i < 8; i++) begin
      lo = $random(seed);
      hi = $random(seed);
      hi[7:6] = i[1:0];
      ctl = {1'b1, 3'b000, i[2], i[2:0]};
      sel = {2'h0, hi[5:0], lo};
      slow <= i[0];
      bus(1'b1, `CPD_IDX_SLOT_LO, lo, 4'hF);
      bus(1'b1, `CPD_IDX_SLOT_HI, hi, 4'hF);
      rd(`CPD_IDX_SLOT_HI, hi);
      rd(`CPD_IDX_SLOT_LO, lo);
      bus(1'b1, `CPD_IDX_CTL, ctl | 8'h70, 4'h1);
      rd(`CPD_IDX_CTL, ctl);
      for (s = 0; s < 16; s++) begin
        if (sel[s] && i[2:0] != 3'h0) begin
          last = s[3:0];
          for (b = 0; b <= i[1:0]; b++)
            beat_q.push_back(cpd_pkg::cpd_beat_t'({i[2], i[2:0], s[3:0], b == i[1:0]}));
        end
        strobe(s[3:0]);
      end
    end
    // status: idle, no overrun, slot of the last finished group
    rd(`CPD_IDX_STATUS, {last, 4'h0});
    bus(1'b1, `CPD_IDX_SLOT_LO, 8'hFF, 4'hF);
    // a repeated strobe on a busy slot is lost and leaves the sticky overrun flag
    for (b = 0; b < 4; b++)
      beat_q.push_back(cpd_pkg::cpd_beat_t'({1'b1, 3'h7, 4'h0, b == 3}));
    strobe(4'h0, 2);
    rd(`CPD_IDX_STATUS, 8'h02);
    bus(1'b1, `CPD_IDX_STATUS, 8'h02, 4'hF);
    rd(`CPD_IDX_STATUS, 8'h00);
    bus(1'b1, `CPD_IDX_CTL, 8'h0F, 4'hF);
    for (s = 0; s < 8; s++)
      strobe(s[3:0]);
    tally_and_finish();
  end
endmodule
